// ### rtl/soi_pkg.sv
package soi_pkg;
  localparam logic [11:0] SOI_CTRL1_ADDR    = 12'h702;
  localparam logic [11:0] SOI_S1_ADDR       = 12'h73b;
  localparam logic [11:0] SOI_F1_ADDR       = 12'h73f;
  localparam logic [11:0] SOI_E1_ADDR       = 12'h743;
  localparam logic [11:0] SOI_E2_ADDR       = 12'h747;
  localparam logic [11:0] SOI_J0V_ADDR      = 12'h74b;
  localparam logic [11:0] SOI_J0C_ADDR      = 12'h74f;
  localparam logic [11:0] SOI_TRACE_BASE    = 12'h900;
  localparam logic [11:0] SOI_TRACE_LAST    = 12'h93f;
  localparam int          SOI_S1_BIT        = 2;
  localparam int          SOI_F1_BIT        = 3;
  localparam int          SOI_E1_BIT        = 4;
  localparam int          SOI_E2_BIT        = 5;
  localparam logic [7:0]  SOI_CTRL1_MASK    = 8'h3c;
  localparam logic [7:0]  SOI_J0C_MASK      = 8'h0f;
  localparam logic [7:0]  SOI_RESET_VALUE   = 8'h00;
  localparam logic [7:0]  SOI_J0_FIXED      = 8'h01;
  localparam logic [5:0]  SOI_LAST_LEN1     = 6'h00;
  localparam logic [5:0]  SOI_LAST_LEN16    = 6'h0f;
  localparam logic [5:0]  SOI_LAST_LEN64    = 6'h3f;
  localparam logic [1:0]  SOI_SRC_FIXED     = 2'h0;
  localparam logic [1:0]  SOI_SRC_BUFFER    = 2'h1;
  localparam logic [1:0]  SOI_SRC_VALUE     = 2'h2;
  localparam logic [1:0]  SOI_SRC_PIN       = 2'h3;
  localparam logic [2:0]  SOI_POS_NONE      = 3'h0;
  localparam logic [2:0]  SOI_POS_S1        = 3'h1;
  localparam logic [2:0]  SOI_POS_F1        = 3'h2;
  localparam logic [2:0]  SOI_POS_E1        = 3'h3;
  localparam logic [2:0]  SOI_POS_E2        = 3'h4;
  localparam logic [2:0]  SOI_POS_J0        = 3'h5;

  typedef struct packed {
    logic [7:0] tx_control_1;
    logic [7:0] sync_status_byte_value;
    logic [7:0] user_channel_byte_value;
    logic [7:0] section_orderwire_byte_value;
    logic [7:0] multiplex_orderwire_byte_value;
    logic [7:0] trace_byte_value;
    logic [7:0] trace_control;
    logic [5:0] trace_ptr;
    logic [7:0] data;
    logic       valid;
    logic [7:0] rd_data;
  } soi_state_type;
endpackage

// ### rtl/soi_insert.sv
`timescale 1ns/10ps
// Operation
// - S1 byte takes its value register when control bit 2 is set.
// - F1 byte takes its value register when control bit 3 is set.
// - E1 byte takes its value register when control bit 4 is set.
// - E2 byte takes its value register when control bit 5 is set.
// - Trace source 00 sends fixed 0x01 in every J0 byte.
// - Trace source 01 sends J0 bytes from the 64-byte trace buffer.
// - Trace source 10 sends the trace value register in J0.
// - Trace source 11 sends the external overhead pin byte in J0.
// - Length code 00 gives 1 byte, 01 gives 16, 1x gives 64.
// - A new trace value appears in the very next J0 byte.
module soi_insert
  import soi_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rd_data_out,
  input  wire logic [7:0]        data_in,
  input  wire logic              valid_in,
  input  wire logic [2:0]        oh_pos_in,
  input  wire logic [7:0]        external_section_overhead_in,
  output logic      [7:0]        data_out,
  output logic                   valid_out
);

  if (ADDR_W < 12) begin : g_addr_w_check
    $error("soi_insert: ADDR_W must be at least 12");
  end

  soi_state_type r;
  soi_state_type next_r;
  logic [7:0]    trace_mem [0:63];
  logic [11:0]   addr;
  logic          in_buf;
  logic [5:0]    last_idx;
  logic          j0_slot;

  assign addr    = addr_in[11:0];
  assign in_buf  = (addr >= SOI_TRACE_BASE) && (addr <= SOI_TRACE_LAST);
  assign j0_slot = valid_in && (oh_pos_in == SOI_POS_J0);

  always_comb begin
    next_r = r;
    // Length code decode for the trace buffer wrap point.
    unique case (r.trace_control[3:2])
      2'h0:    last_idx = SOI_LAST_LEN1;
      2'h1:    last_idx = SOI_LAST_LEN16;
      default: last_idx = SOI_LAST_LEN64;
    endcase
    if (wr_in) begin
      unique case (addr)
        SOI_CTRL1_ADDR: next_r.tx_control_1 = wr_data_in & SOI_CTRL1_MASK;
        SOI_S1_ADDR:    next_r.sync_status_byte_value = wr_data_in;
        SOI_F1_ADDR:    next_r.user_channel_byte_value = wr_data_in;
        SOI_E1_ADDR:    next_r.section_orderwire_byte_value = wr_data_in;
        SOI_E2_ADDR:    next_r.multiplex_orderwire_byte_value = wr_data_in;
        SOI_J0V_ADDR:   next_r.trace_byte_value = wr_data_in;
        SOI_J0C_ADDR:   next_r.trace_control = wr_data_in & SOI_J0C_MASK;
        default:        next_r.tx_control_1 = r.tx_control_1;
      endcase
    end
    next_r.rd_data = 8'h00;
    if (rd_in) begin
      if (in_buf) begin
        next_r.rd_data = trace_mem[addr[5:0]];
      end else begin
        unique case (addr)
          SOI_CTRL1_ADDR: next_r.rd_data = r.tx_control_1;
          SOI_S1_ADDR:    next_r.rd_data = r.sync_status_byte_value;
          SOI_F1_ADDR:    next_r.rd_data = r.user_channel_byte_value;
          SOI_E1_ADDR:    next_r.rd_data = r.section_orderwire_byte_value;
          SOI_E2_ADDR:    next_r.rd_data = r.multiplex_orderwire_byte_value;
          SOI_J0V_ADDR:   next_r.rd_data = r.trace_byte_value;
          SOI_J0C_ADDR:   next_r.rd_data = r.trace_control;
          default:        next_r.rd_data = 8'h00;
        endcase
      end
    end
    next_r.valid = valid_in;
    next_r.data  = data_in;
    if (valid_in) begin
      unique case (oh_pos_in)
        SOI_POS_S1: begin
          if (r.tx_control_1[SOI_S1_BIT]) begin
            next_r.data = r.sync_status_byte_value;
          end
        end
        SOI_POS_F1: begin
          if (r.tx_control_1[SOI_F1_BIT]) begin
            next_r.data = r.user_channel_byte_value;
          end
        end
        SOI_POS_E1: begin
          if (r.tx_control_1[SOI_E1_BIT]) begin
            next_r.data = r.section_orderwire_byte_value;
          end
        end
        SOI_POS_E2: begin
          if (r.tx_control_1[SOI_E2_BIT]) begin
            next_r.data = r.multiplex_orderwire_byte_value;
          end
        end
        SOI_POS_J0: begin
          unique case (r.trace_control[1:0])
            SOI_SRC_FIXED:  next_r.data = SOI_J0_FIXED;
            SOI_SRC_BUFFER: next_r.data = trace_mem[r.trace_ptr];
            SOI_SRC_VALUE:  next_r.data = r.trace_byte_value;
            SOI_SRC_PIN:    next_r.data = external_section_overhead_in;
          endcase
        end
        default: next_r.data = data_in;
      endcase
    end
    // In buffer mode the trace pointer steps once per J0 slot and wraps at the length; in other modes it is held at 0.
    if (r.trace_control[1:0] != SOI_SRC_BUFFER) begin
      next_r.trace_ptr = 6'h00;
    end else if (j0_slot) begin
      if (r.trace_ptr >= last_idx) begin
        next_r.trace_ptr = 6'h00;
      end else begin
        next_r.trace_ptr = r.trace_ptr + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_in && in_buf) begin
      trace_mem[addr[5:0]] <= wr_data_in;
    end
  end

  assign rd_data_out = r.rd_data;
  assign data_out    = r.data;
  assign valid_out   = r.valid;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_s1_insert: assert property (
    valid_in && oh_pos_in == SOI_POS_S1 && r.tx_control_1[SOI_S1_BIT]
    |=> data_out == $past(r.sync_status_byte_value))
    else $error("S1 byte not taken from its register");
  chk_s1_pass: assert property (
    valid_in && oh_pos_in == SOI_POS_S1 && !r.tx_control_1[SOI_S1_BIT]
    |=> data_out == $past(data_in))
    else $error("S1 byte altered while insertion is off");
  chk_f1_insert: assert property (
    valid_in && oh_pos_in == SOI_POS_F1 && r.tx_control_1[SOI_F1_BIT]
    |=> data_out == $past(r.user_channel_byte_value))
    else $error("F1 byte not taken from its register");
  chk_e1_insert: assert property (
    valid_in && oh_pos_in == SOI_POS_E1 && r.tx_control_1[SOI_E1_BIT]
    |=> data_out == $past(r.section_orderwire_byte_value))
    else $error("E1 byte not taken from its register");
  chk_e2_insert: assert property (
    valid_in && oh_pos_in == SOI_POS_E2 && r.tx_control_1[SOI_E2_BIT]
    |=> data_out == $past(r.multiplex_orderwire_byte_value))
    else $error("E2 byte not taken from its register");
  chk_j0_fixed: assert property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_FIXED
    |=> valid_out && data_out == SOI_J0_FIXED)
    else $error("J0 fixed value wrong");
  chk_j0_buffer: assert property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_BUFFER
    |=> data_out == $past(trace_mem[r.trace_ptr]))
    else $error("J0 byte not taken from trace buffer");
  chk_j0_value: assert property (
    wr_in && addr == SOI_J0V_ADDR && r.trace_control[1:0] == SOI_SRC_VALUE
    ##1 !wr_in ##1 j0_slot && !wr_in |=> data_out == $past(wr_data_in, 3))
    else $error("new J0 value not sent in next J0 byte");
  chk_j0_pin: assert property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_PIN
    |=> data_out == $past(external_section_overhead_in))
    else $error("J0 byte not taken from overhead pin");
  chk_len_wrap: assert property (
    j0_slot && r.trace_control == {4'h0, 2'h1, SOI_SRC_BUFFER}
    && r.trace_ptr == SOI_LAST_LEN16 |=> r.trace_ptr == 6'h00)
    else $error("16-byte trace did not wrap");
  chk_ptr_step: assert property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_BUFFER
    && r.trace_control[3:2] != 2'h0 && r.trace_ptr < SOI_LAST_LEN16
    && !(wr_in && addr == SOI_J0C_ADDR)
    |=> r.trace_ptr == $past(r.trace_ptr) + 6'h01)
    else $error("trace pointer did not step");
  chk_ctrl_nibble: assert property (
    rd_in && addr == SOI_J0C_ADDR |=> rd_data_out[7:4] == 4'h0)
    else $error("trace control upper nibble not zero");

  chk_f1_pass: assert property (
    valid_in && oh_pos_in == SOI_POS_F1 && !r.tx_control_1[SOI_F1_BIT]
    |=> data_out == $past(data_in))
    else $error("F1 byte altered while insertion is off");
  chk_e1_pass: assert property (
    valid_in && oh_pos_in == SOI_POS_E1 && !r.tx_control_1[SOI_E1_BIT]
    |=> data_out == $past(data_in))
    else $error("E1 byte altered while insertion is off");
  chk_e2_pass: assert property (
    valid_in && oh_pos_in == SOI_POS_E2 && !r.tx_control_1[SOI_E2_BIT]
    |=> data_out == $past(data_in))
    else $error("E2 byte altered while insertion is off");
  chk_payload_pass: assert property (
    valid_in && (oh_pos_in == SOI_POS_NONE || oh_pos_in > SOI_POS_J0)
    |=> data_out == $past(data_in))
    else $error("payload byte altered");
  chk_valid_follow: assert property (
    1'b1 |=> valid_out == $past(valid_in))
    else $error("valid_out does not follow valid_in");

  chk_j0_reg: assert property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_VALUE
    |=> data_out == $past(r.trace_byte_value))
    else $error("J0 byte not taken from value register");
  chk_len1_hold: assert property (
    j0_slot && r.trace_control == {4'h0, 2'h0, SOI_SRC_BUFFER}
    |=> r.trace_ptr == SOI_LAST_LEN1)
    else $error("1-byte trace pointer moved");
  chk_wrap_64: assert property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_BUFFER
    && r.trace_control[3] && r.trace_ptr == SOI_LAST_LEN64
    |=> r.trace_ptr == 6'h00)
    else $error("64-byte trace did not wrap");
  chk_ptr_idle: assert property (
    r.trace_control[1:0] != SOI_SRC_BUFFER |=> r.trace_ptr == 6'h00)
    else $error("trace pointer not parked outside buffer mode");

  chk_s1_write: assert property (
    wr_in && addr == SOI_S1_ADDR
    |=> r.sync_status_byte_value == $past(wr_data_in))
    else $error("S1 value register write lost");
  chk_f1_write: assert property (
    wr_in && addr == SOI_F1_ADDR
    |=> r.user_channel_byte_value == $past(wr_data_in))
    else $error("F1 value register write lost");
  chk_e1_write: assert property (
    wr_in && addr == SOI_E1_ADDR
    |=> r.section_orderwire_byte_value == $past(wr_data_in))
    else $error("E1 value register write lost");
  chk_e2_write: assert property (
    wr_in && addr == SOI_E2_ADDR
    |=> r.multiplex_orderwire_byte_value == $past(wr_data_in))
    else $error("E2 value register write lost");
  chk_j0v_write: assert property (
    wr_in && addr == SOI_J0V_ADDR
    |=> r.trace_byte_value == $past(wr_data_in))
    else $error("trace value register write lost");
  chk_ctrl1_write: assert property (
    wr_in && addr == SOI_CTRL1_ADDR
    |=> r.tx_control_1 == ($past(wr_data_in) & SOI_CTRL1_MASK))
    else $error("control register write lost");
  chk_j0c_write: assert property (
    wr_in && addr == SOI_J0C_ADDR
    |=> r.trace_control == ($past(wr_data_in) & SOI_J0C_MASK))
    else $error("trace control register write lost");

  chk_rd_idle: assert property (
    !rd_in |=> rd_data_out == 8'h00)
    else $error("read data not cleared after read");
  chk_rd_value: assert property (
    rd_in && addr == SOI_J0V_ADDR
    |=> rd_data_out == $past(r.trace_byte_value))
    else $error("trace value register read wrong");
  chk_rd_buffer: assert property (
    rd_in && in_buf |=> rd_data_out == $past(trace_mem[addr[5:0]]))
    else $error("trace buffer read wrong");
  chk_rd_ctrl1: assert property (
    rd_in && addr == SOI_CTRL1_ADDR
    |=> rd_data_out == $past(r.tx_control_1))
    else $error("control register read wrong");
  chk_rd_sync: assert property (
    rd_in && addr == SOI_S1_ADDR
    |=> rd_data_out == $past(r.sync_status_byte_value))
    else $error("S1 value register read wrong");

  chk_reset_zero: assert property (
    @(posedge clk_in) disable iff (1'b0)
    !resetn_in |=> r == '0)
    else $error("state not cleared by reset");

  cov_buf_wrap64: cover property (
    j0_slot && r.trace_control[1:0] == SOI_SRC_BUFFER
    && r.trace_ptr == SOI_LAST_LEN64);
  cov_pin_j0: cover property (j0_slot && r.trace_control[1:0] == SOI_SRC_PIN);
  cov_s1_ins: cover property (
    valid_in && oh_pos_in == SOI_POS_S1 && r.tx_control_1[SOI_S1_BIT]);
  cov_buf_read: cover property (rd_in && in_buf ##1 rd_data_out != 8'h00);
  cov_j0_renew: cover property (
    wr_in && addr == SOI_J0V_ADDR ##[1:2] j0_slot);

endmodule

// ### verif/soi_rx_model.sv
`timescale 1ns/10ps
module soi_rx_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] data_in,
  input  wire logic       valid_in
);
  logic [7:0] frame_q[$];
  // The far terminal keeps every byte that arrives with valid set.
  always @(posedge clk_in) begin
    if (valid_in === 1'b1) begin
      frame_q.push_back(data_in);
    end
  end
endmodule

// ### verif/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import soi_pkg::*;
  logic        clk_in, resetn_in, wr_in, rd_in, valid_in, valid_out;
  logic [11:0] addr_in;
  logic [7:0]  wr_data_in, data_in, ext_in, rd_data_out, data_out;
  logic [2:0]  oh_pos_in;
  int          fails, cmp_count, n_sent, ptr, len;
  logic [7:0]  rm [logic [11:0]];
  logic [7:0]  mem [64];
  logic [11:0] oh_addr [4] = '{SOI_S1_ADDR, SOI_F1_ADDR, SOI_E1_ADDR,
                               SOI_E2_ADDR};

  soi_insert i_soi_insert (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .data_in(data_in),
    .valid_in(valid_in), .oh_pos_in(oh_pos_in),
    .external_section_overhead_in(ext_in), .data_out(data_out),
    .valid_out(valid_out));
  soi_rx_model i_soi_rx_model (.clk_in(clk_in), .data_in(data_out),
    .valid_in(valid_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a; wr_data_in <= d; wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (a >= SOI_TRACE_BASE && a <= SOI_TRACE_LAST) mem[a[5:0]] = d;
    else if (a == SOI_CTRL1_ADDR) rm[a] = d & SOI_CTRL1_MASK;
    else if (a == SOI_J0C_ADDR) rm[a] = d & SOI_J0C_MASK;
    else if (rm.exists(a)) rm[a] = d;
    if (rm[SOI_J0C_ADDR][1:0] != SOI_SRC_BUFFER) ptr = 0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic [7:0] e;
    e = (a >= SOI_TRACE_BASE && a <= SOI_TRACE_LAST) ? mem[a[5:0]] :
        rm.exists(a) ? rm[a] : 8'h00;
    @(posedge clk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rd_data_out, e)
  endtask

  task automatic send(input logic [2:0] pos);
    logic [7:0] d, x, e, c;
    d = 8'($urandom); x = 8'($urandom); e = d; c = rm[SOI_J0C_ADDR];
    len = (c[3:2] == 2'h0) ? 1 : (c[3:2] == 2'h1) ? 16 : 64;
    if (pos >= SOI_POS_S1 && pos <= SOI_POS_E2)
      if (rm[SOI_CTRL1_ADDR][pos + 1]) e = rm[oh_addr[pos - 1]];
    if (pos == SOI_POS_J0) begin
      case (c[1:0])
        SOI_SRC_FIXED: e = SOI_J0_FIXED;
        SOI_SRC_BUFFER: begin e = mem[ptr]; ptr = (ptr + 1) % len; end
        SOI_SRC_VALUE: e = rm[SOI_J0V_ADDR];
        default: e = x;
      endcase
    end
    @(posedge clk_in);
    data_in <= d; ext_in <= x; oh_pos_in <= pos; valid_in <= 1'b1;
    @(posedge clk_in);
    valid_in <= 1'b0;
    n_sent++;
    #1;
    `CHK(valid_out, 1'b1)
    `CHK(data_out, e)
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    print_verdict();
  end

  initial begin
    resetn_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; valid_in = 1'b0;
    addr_in = '0; wr_data_in = '0; data_in = '0; ext_in = '0;
    oh_pos_in = '0; ptr = 0;
    void'($urandom(32'h4c88db7f));
    foreach (oh_addr[i]) rm[oh_addr[i]] = 8'h00;
    rm[SOI_CTRL1_ADDR] = 8'h00; rm[SOI_J0V_ADDR] = 8'h00;
    rm[SOI_J0C_ADDR] = 8'h00;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (rm[a]) rd(a);
    rd(12'h700);
    wr(12'h700, 8'h5a);
    rd(12'h700);
    wr(SOI_J0C_ADDR, 8'hff);
    rd(SOI_J0C_ADDR);
    wr(SOI_J0C_ADDR, 8'h00);
    for (int m = 0; m < 16; m++) begin
      foreach (oh_addr[i]) wr(oh_addr[i], 8'($urandom));
      wr(SOI_CTRL1_ADDR, 8'($urandom) ^ 8'(m << 2));
      rd(SOI_CTRL1_ADDR);
      for (int p = 0; p < 8; p++) send(3'(p));
    end
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (rm[a]) rm[a] = 8'h00;
    ptr = 0;
    foreach (rm[a]) rd(a);
    for (int i = 0; i < 64; i++) wr(SOI_TRACE_BASE + 12'(i), 8'($urandom));
    rd(SOI_TRACE_BASE);
    rd(SOI_TRACE_LAST);
    for (int s = 0; s < 4; s++) begin
      wr(SOI_J0C_ADDR, 8'(s));
      wr(SOI_J0V_ADDR, 8'($urandom));
      send(SOI_POS_J0);
      send(SOI_POS_J0);
    end
    for (int l = 0; l < 4; l++) begin
      wr(SOI_J0C_ADDR, 8'h00);
      wr(SOI_J0C_ADDR, 8'(l << 2) | 8'h01);
      repeat ((l == 0 ? 1 : l == 1 ? 16 : 64) + 2) send(SOI_POS_J0);
      send(SOI_POS_NONE);
    end
    @(posedge clk_in);
    #1;
    `CHK(i_soi_rx_model.frame_q.size(), n_sent)
    print_verdict();
  end
endmodule
